// >>> core/acs_defines.svh
// Constants for the converter sequencer: timing, widths and codes
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// -----------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------
`define ACS_CLK_MHZ 50
`define ACS_SYNC_US 30
`define ACS_SYNC_CYCLES (`ACS_SYNC_US * `ACS_CLK_MHZ)
`define ACS_DLY_UNIT_US 40
`define ACS_DLY_UNIT_CYCLES (`ACS_DLY_UNIT_US * `ACS_CLK_MHZ)
// Converter clock near 1.33 MHz: 50 MHz / (2 * 19) = 1.316 MHz
`define ACS_CONV_HALF_DIV 5'h13

// -----------------------------------------------------------------
// Widths and codes
// -----------------------------------------------------------------
`define ACS_RES_W 10
`define ACS_SLOTS 8
`define ACS_CNT_W 16
`define ACS_FULL_SCALE 10'h3FF
`define ACS_CH_DIE_TEMP 4'h3
`define ACS_CH_COIN_CELL 4'h8
`define ACS_CH_FIRST_EXT 4'h9
`define ACS_SLOT0 3'h0
`define ACS_DLY_NONE 4'h0

`endif

// >>> core/acs_pkg.sv
// Types shared by the converter sequencer design
`default_nettype none
package acs_pkg;
   typedef enum logic [2:0] {
      ACS_CAL = 3'h0,
      ACS_IDLE = 3'h1,
      ACS_SYNC = 3'h2,
      ACS_DLY_FIRST = 3'h3,
      ACS_CONV_REQ = 3'h4,
      ACS_CONV_WAIT = 3'h5,
      ACS_DLY_BETWEEN = 3'h6,
      ACS_DLY_END = 3'h7
   } acs_state_t;
endpackage
`default_nettype wire

// >>> core/acs_timer.sv
// Down-counting wait timer with a one-cycle expiry pulse
`include "acs_defines.svh"
`default_nettype none
module acs_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [`ACS_CNT_W-1:0] cycles,
   output logic expired
);
   logic [`ACS_CNT_W-1:0] cnt;
   logic running;
   logic [`ACS_CNT_W-1:0] next_cnt;
   logic next_running;
   logic next_expired;

   // A zero load expires on the next edge so a zero delay still ends
   always_comb begin
      next_cnt = cnt;
      next_running = running;
      next_expired = 1'b0;
      if (load) begin
         next_cnt = cycles;
         next_running = 1'b1;
      end else if (running) begin
         if (cnt <= `ACS_CNT_W'(1)) begin
            next_running = 1'b0;
            next_expired = 1'b1;
         end else begin
            next_cnt = cnt - `ACS_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         cnt <= next_cnt;
         running <= next_running;
         expired <= next_expired;
      end
   end
endmodule // acs_timer
`default_nettype wire

// >>> core/acs_result_mem.sv
// Eight-slot result store, read as pairs with registered read data
`include "acs_defines.svh"
`default_nettype none
module acs_result_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [2:0] wr_slot,
   input wire logic [`ACS_RES_W-1:0] wr_data,
   input wire logic [1:0] rd_pair,
   output logic [`ACS_RES_W-1:0] rd_lo,
   output logic [`ACS_RES_W-1:0] rd_hi
);
   logic [`ACS_RES_W-1:0] mem [`ACS_SLOTS];
   logic [`ACS_RES_W-1:0] next_mem [`ACS_SLOTS];

   // One write port; each entry decodes its own enable
   generate
      for (genvar i = 0; i < `ACS_SLOTS; i++) begin : g_slot
         always_comb begin
            next_mem[i] = mem[i];
            if (wr_en && (wr_slot == 3'(i))) begin
               next_mem[i] = wr_data;
            end
         end
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               mem[i] <= '0;
            end else begin
               mem[i] <= next_mem[i];
            end
         end
      end
   endgenerate

   // Pair k holds slots 2k (low) and 2k+1 (high)
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_lo <= '0;
         rd_hi <= '0;
      end else begin
         rd_lo <= mem[{rd_pair, 1'b0}];
         rd_hi <= mem[{rd_pair, 1'b1}];
      end
   end
endmodule // acs_result_mem
`default_nettype wire

// >>> core/acs_sequencer.sv
// Conversion sequencer for the 10-bit multi-channel converter
//
// Summary of operation
// - Sixteen inputs chosen by a four-bit code in each slot.
// - Results are 10 bits; converter clock is divided to about 1.33 MHz.
// - An overrange input saturates the stored result at full scale.
// - Each finished pass sets the done flag; the mask gates the interrupt.
// - Once calibration is done, enable low keeps the converter powered down and the sequencer idle.
// - Offset and gain calibration runs once after every power-up.
// - First conversion waits sync time (30 us) then the initial delay.
// - Each delay code is its value times 40 us.
// - Initial delay before first conversion, inter delay between them.
// - End-of-pass delay applies only in continuous mode.
// - All three delay settings reset to zero.
// - At most eight conversions; each slot's code picks the input.
// - Slots run from zero through the last slot index inclusive.
// - Continuous mode loops passes; it resets to single pass.
// - Hold in continuous mode blocks result updates.
// - Results are read as four pairs of slots.
// - Touch readings take priority and overwrite sequence results.
`include "acs_defines.svh"
`default_nettype none
module acs_sequencer #(
   parameter int unsigned DELAY_UNIT_CYCLES = `ACS_DLY_UNIT_CYCLES,
   parameter int unsigned SYNC_CYCLES = `ACS_SYNC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic converter_enable,
   input wire logic sequence_start,
   input wire logic [31:0] slot_channel_select,
   input wire logic [2:0] last_slot_index,
   input wire logic continuous_loop,
   input wire logic result_update_hold,
   input wire logic [3:0] initial_delay,
   input wire logic [3:0] inter_conversion_delay,
   input wire logic [3:0] end_of_pass_delay,
   input wire logic conversion_done_mask,
   input wire logic done_flag_clear,
   input wire logic [1:0] result_pair_select,
   input wire logic cal_done,
   input wire logic conv_done,
   input wire logic [`ACS_RES_W-1:0] conv_data,
   input wire logic conv_overrange,
   input wire logic touch_busy,
   input wire logic touch_wr,
   input wire logic [2:0] touch_slot,
   input wire logic [`ACS_RES_W-1:0] touch_data,
   output logic converter_power_down,
   output logic conv_clk,
   output logic cal_start,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic sequence_busy,
   output logic conversion_done_flag,
   output logic irq,
   output logic [`ACS_RES_W-1:0] slot_result_lo,
   output logic [`ACS_RES_W-1:0] slot_result_hi
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;
   logic [2:0] slot;
   logic [2:0] next_slot;
   logic [3:0] dly_first;
   logic [3:0] dly_between;
   logic [3:0] dly_end;
   logic tmr_load;
   logic next_tmr_load;
   logic [`ACS_CNT_W-1:0] tmr_cycles;
   logic [`ACS_CNT_W-1:0] next_tmr_cycles;
   logic tmr_expired;
   logic next_cal_start;
   logic next_conv_start;
   logic [3:0] next_conv_channel;
   logic pass_end;
   logic res_wr;
   logic [`ACS_RES_W-1:0] res_data;
   logic mem_wr;
   logic [2:0] mem_slot;
   logic [`ACS_RES_W-1:0] mem_data;
   logic next_flag;
   logic next_irq;
   logic [4:0] div_cnt;
   logic [4:0] next_div_cnt;
   logic next_conv_clk;

   // Delay code to cycles: code times the 40 us unit
   function automatic logic [`ACS_CNT_W-1:0] dly_cycles(
      input logic [3:0] code
   );
      dly_cycles = `ACS_CNT_W'(code) * `ACS_CNT_W'(DELAY_UNIT_CYCLES);
   endfunction

   // ---------------------------------------------------------------
   // Delay settings
   // ---------------------------------------------------------------
   // Local copies so the delays read zero straight after reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dly_first <= `ACS_DLY_NONE;
         dly_between <= `ACS_DLY_NONE;
         dly_end <= `ACS_DLY_NONE;
      end else begin
         dly_first <= initial_delay;
         dly_between <= inter_conversion_delay;
         dly_end <= end_of_pass_delay;
      end
   end

   // ---------------------------------------------------------------
   // Converter clock divider
   // ---------------------------------------------------------------
   // Stopped while powered down to save power
   always_comb begin
      next_div_cnt = div_cnt;
      next_conv_clk = conv_clk;
      if (!converter_enable) begin
         next_div_cnt = '0;
         next_conv_clk = 1'b0;
      end else if (div_cnt == `ACS_CONV_HALF_DIV - 5'h01) begin
         next_div_cnt = '0;
         next_conv_clk = ~conv_clk;
      end else begin
         next_div_cnt = div_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt <= '0;
         conv_clk <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         conv_clk <= next_conv_clk;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer state machine
   // ---------------------------------------------------------------
   assign pass_end = (slot == last_slot_index);

   always_comb begin
      next_state = state;
      next_slot = slot;
      next_tmr_load = 1'b0;
      next_tmr_cycles = tmr_cycles;
      next_cal_start = 1'b0;
      next_conv_start = 1'b0;
      next_conv_channel = conv_channel;
      unique case (state)
         acs_pkg::ACS_CAL: begin
            // Calibration needs no processor action after power-up
            next_cal_start = !cal_done;
            if (cal_done) begin
               next_state = acs_pkg::ACS_IDLE;
            end
         end
         acs_pkg::ACS_IDLE: begin
            next_slot = `ACS_SLOT0;
            // Start while disabled is dropped, not remembered
            if (sequence_start && converter_enable) begin
               next_state = acs_pkg::ACS_SYNC;
               next_tmr_load = 1'b1;
               next_tmr_cycles = `ACS_CNT_W'(SYNC_CYCLES);
            end
         end
         acs_pkg::ACS_SYNC: begin
            if (tmr_expired) begin
               next_state = acs_pkg::ACS_DLY_FIRST;
               next_tmr_load = 1'b1;
               next_tmr_cycles = dly_cycles(dly_first);
            end
         end
         acs_pkg::ACS_DLY_FIRST, acs_pkg::ACS_DLY_BETWEEN,
         acs_pkg::ACS_DLY_END: begin
            if (tmr_expired) begin
               next_state = acs_pkg::ACS_CONV_REQ;
            end
         end
         acs_pkg::ACS_CONV_REQ: begin
            // Touch readings own the converter; wait them out
            if (!touch_busy) begin
               next_conv_start = 1'b1;
               next_conv_channel = slot_channel_select[slot*4 +: 4];
               next_state = acs_pkg::ACS_CONV_WAIT;
            end
         end
         acs_pkg::ACS_CONV_WAIT: begin
            if (conv_done) begin
               next_tmr_load = 1'b1;
               if (!pass_end) begin
                  next_slot = slot + 3'h1;
                  next_state = acs_pkg::ACS_DLY_BETWEEN;
                  next_tmr_cycles = dly_cycles(dly_between);
               end else if (continuous_loop) begin
                  next_slot = `ACS_SLOT0;
                  next_state = acs_pkg::ACS_DLY_END;
                  next_tmr_cycles = dly_cycles(dly_end);
               end else begin
                  next_tmr_load = 1'b0;
                  next_state = acs_pkg::ACS_IDLE;
               end
            end
         end
      endcase
      // Dropping enable abandons any sequence in flight
      if (!converter_enable && state != acs_pkg::ACS_CAL) begin
         next_state = acs_pkg::ACS_IDLE;
         next_tmr_load = 1'b0;
         next_conv_start = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= acs_pkg::ACS_CAL;
         slot <= `ACS_SLOT0;
         tmr_load <= 1'b0;
         tmr_cycles <= '0;
         cal_start <= 1'b0;
         conv_start <= 1'b0;
         conv_channel <= `ACS_CH_DIE_TEMP;
      end else begin
         state <= next_state;
         slot <= next_slot;
         tmr_load <= next_tmr_load;
         tmr_cycles <= next_tmr_cycles;
         cal_start <= next_cal_start;
         conv_start <= next_conv_start;
         conv_channel <= next_conv_channel;
      end
   end

   // ---------------------------------------------------------------
   // Status outputs
   // ---------------------------------------------------------------
   // Calibration start is a level during the calibration state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         converter_power_down <= 1'b1;
         sequence_busy <= 1'b0;
      end else begin
         converter_power_down <= !converter_enable
            && next_state != acs_pkg::ACS_CAL;
         sequence_busy <= next_state != acs_pkg::ACS_IDLE
            && next_state != acs_pkg::ACS_CAL;
      end
   end

   // ---------------------------------------------------------------
   // Shared wait timer
   // ---------------------------------------------------------------
   acs_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .cycles(tmr_cycles),
      .expired(tmr_expired)
   );

   // ---------------------------------------------------------------
   // Result write path
   // ---------------------------------------------------------------
   // Hold only matters in continuous mode, where passes overwrite
   assign res_wr = state == acs_pkg::ACS_CONV_WAIT && conv_done
      && converter_enable
      && !(continuous_loop && result_update_hold);
   assign res_data = conv_overrange ? `ACS_FULL_SCALE : conv_data;

   // Touch data wins a same-cycle collision; it would overwrite anyway
   always_comb begin
      mem_wr = res_wr;
      mem_slot = slot;
      mem_data = res_data;
      if (touch_wr) begin
         mem_wr = 1'b1;
         mem_slot = touch_slot;
         mem_data = touch_data;
      end
   end

   acs_result_mem u_results (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(mem_wr),
      .wr_slot(mem_slot),
      .wr_data(mem_data),
      .rd_pair(result_pair_select),
      .rd_lo(slot_result_lo),
      .rd_hi(slot_result_hi)
   );

   // ---------------------------------------------------------------
   // Done flag and interrupt
   // ---------------------------------------------------------------
   // Set beats clear so a pass ending during the clear is not lost
   always_comb begin
      next_flag = conversion_done_flag;
      if (done_flag_clear) begin
         next_flag = 1'b0;
      end
      if (state == acs_pkg::ACS_CONV_WAIT && conv_done && pass_end
         && converter_enable) begin
         next_flag = 1'b1;
      end
      next_irq = next_flag && !conversion_done_mask;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conversion_done_flag <= 1'b0;
         irq <= 1'b0;
      end else begin
         conversion_done_flag <= next_flag;
         irq <= next_irq;
      end
   end

endmodule // acs_sequencer
`default_nettype wire

// >>> dv/acs_sequencer_chk.sv
// Port checker for the converter sequencer
`default_nettype none
module acs_sequencer_chk #(
   parameter int unsigned DELAY_UNIT_CYCLES = 2000,
   parameter int unsigned SYNC_CYCLES = 1500
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic converter_enable,
   input wire logic continuous_loop,
   input wire logic [3:0] initial_delay,
   input wire logic conversion_done_mask,
   input wire logic cal_done,
   input wire logic converter_power_down,
   input wire logic conv_clk,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic sequence_busy,
   input wire logic conversion_done_flag,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cal_seen;
   logic first;
   logic [15:0] age;
   logic next_cal_seen;
   logic next_first;
   logic [15:0] next_age;
   // ------------
   // Helpers
   // ------------
   // Busy age saturates, so a long loop never wraps it back to zero
   always_comb begin
      next_cal_seen = cal_seen | cal_done;
      next_first = !sequence_busy | (first & !conv_start);
      next_age = sequence_busy ? age + {15'h0, ~&age} : 16'h0;
   end
   always_ff @(posedge clk) begin
      cal_seen <= rst_n & next_cal_seen;
      first <= !rst_n | next_first;
      age <= rst_n ? next_age : 16'h0;
   end
   // ------------
   // Properties
   // ------------
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_off;
      !converter_enable ##1 !converter_enable;
   endsequence
   sequence s_unmasked;
      (conversion_done_flag && !conversion_done_mask)[*2];
   endsequence
   property p_cal;
      !cal_seen |-> !sequence_busy;
   endproperty
   a_cal: assert property (p_cal)
      else $error("busy before calibration");
   property p_pd;
      cal_seen ##0 s_off |-> converter_power_down;
   endproperty
   a_pd: assert property (p_pd)
      else $error("converter powered while disabled");
   property p_no_conv;
      s_off |-> !conv_start && !conv_clk;
   endproperty
   a_no_conv: assert property (p_no_conv)
      else $error("conversion activity while disabled");
   property p_first;
      conv_start && first |->
         age >= SYNC_CYCLES + initial_delay * DELAY_UNIT_CYCLES;
   endproperty
   a_first: assert property (p_first)
      else $error("first conversion too early");
   property p_pulse;
      conv_start |-> sequence_busy ##1 !conv_start;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("conversion request not a single pulse");
   property p_chan;
      conv_start |=> $stable(conv_channel)[*3];
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel code moved during conversion");
   property p_irq_mask;
      conversion_done_mask[*2] |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("masked interrupt asserted");
   property p_irq_set;
      s_unmasked |-> irq;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("unmasked done flag gave no interrupt");
   property p_single;
      $rose(conversion_done_flag) && !continuous_loop |->
         ##[0:2] !sequence_busy;
   endproperty
   a_single: assert property (p_single)
      else $error("single pass did not end");
endmodule // acs_sequencer_chk
bind acs_sequencer acs_sequencer_chk #(
   .DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES), .SYNC_CYCLES(SYNC_CYCLES)
) u_chk (
   .clk(clk), .rst_n(rst_n), .converter_enable(converter_enable),
   .continuous_loop(continuous_loop), .initial_delay(initial_delay),
   .conversion_done_mask(conversion_done_mask), .cal_done(cal_done),
   .converter_power_down(converter_power_down), .conv_clk(conv_clk),
   .conv_start(conv_start), .conv_channel(conv_channel),
   .sequence_busy(sequence_busy), .irq(irq),
   .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// >>> dv/acs_analog_model.sv
// Behavioural analog core facing the converter sequencer
`default_nettype none
module acs_analog_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cal_start,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic [5:0] salt,
   input wire logic ovr,
   input wire logic slow,
   output logic cal_done,
   output logic conv_done,
   output logic [9:0] conv_data,
   output logic conv_overrange,
   output logic [15:0] conv_count
);
   timeunit 1ns;
   timeprecision 1ps;
   int cal_cnt;
   int wait_cnt;
   logic [3:0] ch;
   // Data is valid only with conv_done; it toggles between answers
   always @(posedge clk) begin
      conv_done <= 1'b0;
      conv_overrange <= 1'b0;
      conv_data <= ~conv_data;
      if (!rst_n) begin
         cal_cnt <= 0;
         cal_done <= 1'b0;
         wait_cnt <= 0;
         conv_count <= 16'h0;
         conv_data <= 10'h155;
      end else begin
         if (cal_start) cal_cnt <= cal_cnt + 1;
         cal_done <= (cal_cnt >= 19);
         if (conv_start) begin
            wait_cnt <= slow ? 9 : 2;
            ch <= conv_channel;
            conv_count <= conv_count + 16'h1;
         end else if (wait_cnt == 1) begin
            conv_done <= 1'b1;
            conv_data <= {ch, salt};
            conv_overrange <= ovr && ch == 4'hA;
         end
         if (!conv_start && wait_cnt != 0) wait_cnt <= wait_cnt - 1;
      end
   end
endmodule // acs_analog_model
`default_nettype wire

// >>> dv/acs_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`default_nettype none
module acs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int U = 4;
   localparam int S = 3;
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, start = 1'b0;
   logic cont = 1'b0, hold = 1'b0, mask = 1'b0, clr = 1'b0;
   logic tbusy = 1'b0, twr = 1'b0, ovr = 1'b0, slow = 1'b0;
   logic [31:0] sel = 32'hFDCB_A983;
   logic [2:0] last = 3'h0, tslot = 3'h5;
   logic [3:0] d1 = 4'h0, d2 = 4'h0, d3 = 4'hF;
   logic [1:0] psel = 2'h0;
   logic [9:0] tdata = 10'h2A5;
   logic [5:0] salt = 6'h11;
   logic cal_done, conv_done, conv_ovr, pd, cclk, cal_start, cs, busy;
   logic flag, irq;
   logic [3:0] cch;
   logic [9:0] conv_data, lo, hi;
   logic [15:0] ncv;
   logic [9:0] exp_r [8];
   int err_count = 0, comparisons = 0, cyc = 0, k, n0;
   acs_sequencer #(.DELAY_UNIT_CYCLES(U), .SYNC_CYCLES(S)) dut_u (
      .clk(clk), .rst_n(rst_n), .converter_enable(en),
      .sequence_start(start), .slot_channel_select(sel),
      .last_slot_index(last), .continuous_loop(cont),
      .result_update_hold(hold), .initial_delay(d1),
      .inter_conversion_delay(d2), .end_of_pass_delay(d3),
      .conversion_done_mask(mask), .done_flag_clear(clr),
      .result_pair_select(psel), .cal_done(cal_done),
      .conv_done(conv_done), .conv_data(conv_data),
      .conv_overrange(conv_ovr), .touch_busy(tbusy), .touch_wr(twr),
      .touch_slot(tslot), .touch_data(tdata),
      .converter_power_down(pd), .conv_clk(cclk), .cal_start(cal_start),
      .conv_start(cs), .conv_channel(cch), .sequence_busy(busy),
      .conversion_done_flag(flag), .irq(irq), .slot_result_lo(lo),
      .slot_result_hi(hi));
   acs_analog_model model_u (.clk(clk), .rst_n(rst_n), .conv_start(cs),
      .cal_start(cal_start), .conv_channel(cch), .salt(salt), .ovr(ovr),
      .slow(slow),
      .cal_done(cal_done), .conv_done(conv_done), .conv_data(conv_data),
      .conv_overrange(conv_ovr), .conv_count(ncv));
   // Clock and a hang guard well above the expected run length
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         test_done();
      end
   end
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Clears the flag, optionally starts, then waits for the pass end
   task automatic go(input logic st);
      clr = 1'b1;
      start = st;
      step();
      clr = 1'b0;
      start = 1'b0;
      k = 0;
      while (flag !== 1'b1 && k < 4000) begin
         step();
         k++;
      end
      chk(flag, 1'b1);
   endtask
   task automatic wcs();
      k = 0;
      while (cs !== 1'b1 && k < 2000) begin
         step();
         k++;
      end
      chk(cs, 1);
   endtask
   task automatic fill(input int l);
      for (int s = 0; s <= l; s++) begin
         exp_r[s] = {sel[4*s+:4], salt};
         if (ovr && sel[4*s+:4] == 4'hA) exp_r[s] = 10'h3FF;
      end
   endtask
   task automatic rd_all();
      for (int p = 0; p < 4; p++) begin
         psel = p[1:0];
         step(2);
         chk(lo, exp_r[2*p]);
         chk(hi, exp_r[2*p+1]);
      end
   endtask
   task automatic run(input logic [2:0] l);
      n0 = ncv;
      last = l;
      go(1'b1);
      chk(ncv - n0, l + 1);
      fill(l);
      rd_all();
   endtask
   task automatic t_off();
      en = 1'b0;
      start = 1'b1;
      step();
      start = 1'b0;
      step(40);
      chk(ncv, 0);
      chk({flag, pd}, 2'h1);
      en = 1'b1;
      step(2);
      chk(pd, 0);
   endtask
   task automatic t_dly();
      d1 = 4'hF;
      d2 = 4'hF;
      slow = 1'b1;
      last = 3'h1;
      start = 1'b1;
      step();
      start = 1'b0;
      wcs();
      chk(k >= S + 15 * U && k <= S + 15 * U + 8, 1);
      step();
      wcs();
      chk(k >= 15 * U, 1);
      go(1'b0);
      {d1, d2, slow} = 9'h0;
   endtask
   task automatic t_mask();
      mask = 1'b1;
      run(3'h0);
      chk(irq, 0);
      mask = 1'b0;
      step(2);
      chk(irq, 1);
      clr = 1'b1;
      step();
      clr = 1'b0;
      step(2);
      chk({flag, irq}, 2'h0);
   endtask
   task automatic t_cont();
      cont = 1'b1;
      salt = 6'h2C;
      run(3'h0);
      wcs();
      step();
      wcs();
      chk(k >= 15 * U, 1);
      hold = 1'b1;
      salt = 6'h07;
      go(1'b0);
      go(1'b0);
      rd_all();
      hold = 1'b0;
      go(1'b0);
      go(1'b0);
      fill(0);
      rd_all();
      en = 1'b0;
      step(3);
      chk(busy, 0);
      {en, cont} = 2'h2;
   endtask
   task automatic t_touch();
      twr = 1'b1;
      step();
      twr = 1'b0;
      exp_r[5] = tdata;
      rd_all();
      tbusy = 1'b1;
      n0 = ncv;
      start = 1'b1;
      step();
      start = 1'b0;
      step(40);
      chk(ncv - n0, 0);
      tbusy = 1'b0;
      go(1'b0);
      chk(ncv - n0, 1);
   endtask
   task automatic test_done();
      $display("err_count=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Start in calibration is ignored; then each scenario in turn
   initial begin
      exp_r = '{default: 10'h0};
      step(10);
      {rst_n, en, start} = 3'h7;
      step();
      chk(cal_start, 1);
      start = 1'b0;
      step(30);
      chk(ncv, 0);
      chk(cal_start, 0);
      rd_all();
      t_off();
      run(3'h2);
      ovr = 1'b1;
      salt = 6'h3A;
      run(3'h7);
      ovr = 1'b0;
      t_dly();
      t_mask();
      t_cont();
      t_touch();
      test_done();
   end
endmodule // acs_sequencer_tb
`default_nettype wire
